// File: rtl/gdio_cfg.svh
// Register offsets, field positions, reset values of the digital I/O port
`ifndef GDIO_CFG_SVH
`define GDIO_CFG_SVH

// ****************************************
// Register byte offsets
// ****************************************
`define GDIO_OFF_OUT     8'h00
`define GDIO_OFF_DIR     8'h04
`define GDIO_OFF_PIN     8'h08
`define GDIO_OFF_SFC     8'h0C
`define GDIO_OFF_DIR_SET 8'h10
`define GDIO_OFF_DIR_CLR 8'h14
`define GDIO_OFF_OUT_SET 8'h18
`define GDIO_OFF_OUT_CLR 8'h1C
`define GDIO_OFF_SLEEP   8'h20
`define GDIO_OFF_EXTINT  8'h24

// ****************************************
// Field positions
// ****************************************
`define GDIO_PUD_BIT     2
`define GDIO_SLEEP_BIT   0

// ****************************************
// Reset values and bus answers
// ****************************************
`define GDIO_RST_PORT    8'h00
`define GDIO_RESP_OKAY   2'h0
`define GDIO_RESP_SLVERR 2'h2

`endif

// File: rtl/gdio_pkg.sv
// Types shared by the digital I/O port
package gdio_pkg;

   // Bus response code
   typedef logic [1:0] gdio_resp_t;

   // Register operation on a port byte
   typedef enum logic [1:0] {
      GDIO_OP_KEEP,
      GDIO_OP_LOAD,
      GDIO_OP_SET,
      GDIO_OP_CLR
   } gdio_op_e;

   // Write channel progress
   typedef enum {
      GDIO_WR_COLLECT,
      GDIO_WR_RESP
   } gdio_wr_e;

endpackage

// File: rtl/gdio_port.sv
// General digital I/O port with an AXI4-Lite register slave
//
// Local design decisions: the placing of the registers and register access over AXI4-Lite.
`timescale 1ns/10ps
`include "gdio_cfg.svh"

module gdio_port #(
   parameter int PINS = 8
) (
   // Clock and reset
   input  wire logic              aclk,
   input  wire logic              aresetn,
   // AXI4-Lite write address
   input  wire logic [7:0]        s_axi_awaddr,
   input  wire logic              s_axi_awvalid,
   output logic                   s_axi_awready,
   // AXI4-Lite write data
   input  wire logic [31:0]       s_axi_wdata,
   input  wire logic [3:0]        s_axi_wstrb,
   input  wire logic              s_axi_wvalid,
   output logic                   s_axi_wready,
   // AXI4-Lite write response
   output gdio_pkg::gdio_resp_t   s_axi_bresp,
   output logic                   s_axi_bvalid,
   input  wire logic              s_axi_bready,
   // AXI4-Lite read address
   input  wire logic [7:0]        s_axi_araddr,
   input  wire logic              s_axi_arvalid,
   output logic                   s_axi_arready,
   // AXI4-Lite read data
   output logic [31:0]            s_axi_rdata,
   output gdio_pkg::gdio_resp_t   s_axi_rresp,
   output logic                   s_axi_rvalid,
   input  wire logic              s_axi_rready,
   // Alternate function overrides, same clock
   input  wire logic [PINS-1:0]   alt_enable,
   input  wire logic [PINS-1:0]   alt_drive_enable,
   input  wire logic [PINS-1:0]   alt_drive_value,
   // Port pads
   input  wire logic [PINS-1:0]   pad_in,
   output logic [PINS-1:0]        pad_out,
   output logic [PINS-1:0]        pad_oe,
   output logic [PINS-1:0]        pad_pullup_en
);
   import gdio_pkg::*;

   // ****************************************
   // Helpers
   // ****************************************

   // Apply one register operation to a port byte
   function automatic logic [PINS-1:0] apply_op(
      input gdio_op_e        op,
      input logic [PINS-1:0] old,
      input logic [PINS-1:0] val
   );
      logic [PINS-1:0] res;
      res = old;
      case (op)
         GDIO_OP_LOAD: res = val;
         GDIO_OP_SET:  res = old | val;
         GDIO_OP_CLR:  res = old & ~val;
         default:      res = old;
      endcase
      return res;
   endfunction

   // Widen a port byte to the bus word
   function automatic logic [31:0] widen(input logic [PINS-1:0] v);
      logic [31:0] w;
      w = '0;
      w[PINS-1:0] = v;
      return w;
   endfunction

   // ****************************************
   // State
   // ****************************************
   gdio_wr_e        wr_state_q, wr_state_d;
   logic            aw_have_q, aw_have_d;
   logic            w_have_q, w_have_d;
   logic [7:0]      wa_q, wa_d;
   logic [31:0]     wd_q, wd_d;
   logic [3:0]      ws_q, ws_d;
   logic            awready_q, awready_d;
   logic            wready_q, wready_d;
   logic            bvalid_q, bvalid_d;
   gdio_resp_t      bresp_q, bresp_d;
   logic            do_write;
   logic            arready_q;
   logic            rvalid_q;
   logic [31:0]     rdata_q;
   gdio_resp_t      rresp_q;
   logic [PINS-1:0] out_q;
   logic [PINS-1:0] dir_q;
   logic            pud_q;
   logic            sleep_q;
   logic [PINS-1:0] extint_q;
   logic [PINS-1:0] sync_lat;
   logic [PINS-1:0] pin_q;
   logic [PINS-1:0] pad_out_q;
   logic [PINS-1:0] pad_oe_q;
   logic [PINS-1:0] pad_pu_q;

   // ****************************************
   // Write decode
   // ****************************************

   // Register hits of the pending write
   wire lane0    = ws_q[0];
   wire hit_out  = wa_q == `GDIO_OFF_OUT;
   wire hit_dir  = wa_q == `GDIO_OFF_DIR;
   wire hit_pin  = wa_q == `GDIO_OFF_PIN;
   wire hit_sfc  = wa_q == `GDIO_OFF_SFC;
   wire hit_dset = wa_q == `GDIO_OFF_DIR_SET;
   wire hit_dclr = wa_q == `GDIO_OFF_DIR_CLR;
   wire hit_oset = wa_q == `GDIO_OFF_OUT_SET;
   wire hit_oclr = wa_q == `GDIO_OFF_OUT_CLR;
   wire hit_slp  = wa_q == `GDIO_OFF_SLEEP;
   wire hit_ext  = wa_q == `GDIO_OFF_EXTINT;
   wire wr_known = hit_out | hit_dir | hit_pin | hit_sfc | hit_dset
                 | hit_dclr | hit_oset | hit_oclr | hit_slp | hit_ext;
   wire wr_go    = do_write & lane0;
   wire [PINS-1:0] wbyte = wd_q[PINS-1:0];

   // Operation chosen for each port register
   wire gdio_op_e out_op = !wr_go    ? GDIO_OP_KEEP :
                           hit_out   ? GDIO_OP_LOAD :
                           hit_oset  ? GDIO_OP_SET  :
                           hit_oclr  ? GDIO_OP_CLR  : GDIO_OP_KEEP;
   wire gdio_op_e dir_op = !wr_go    ? GDIO_OP_KEEP :
                           hit_dir   ? GDIO_OP_LOAD :
                           hit_dset  ? GDIO_OP_SET  :
                           hit_dclr  ? GDIO_OP_CLR  : GDIO_OP_KEEP;

   // ****************************************
   // Write channel
   // ****************************************

   // Address and data taken in either order, then one response
   always_comb begin
      wr_state_d = wr_state_q;
      aw_have_d  = aw_have_q;
      w_have_d   = w_have_q;
      wa_d       = wa_q;
      wd_d       = wd_q;
      ws_d       = ws_q;
      bvalid_d   = bvalid_q;
      bresp_d    = bresp_q;
      do_write   = 1'b0;
      case (wr_state_q)
         GDIO_WR_COLLECT: begin
            if (s_axi_awvalid && awready_q) begin
               aw_have_d = 1'b1;
               wa_d      = s_axi_awaddr;
            end
            if (s_axi_wvalid && wready_q) begin
               w_have_d = 1'b1;
               wd_d     = s_axi_wdata;
               ws_d     = s_axi_wstrb;
            end
            if (aw_have_q && w_have_q) begin
               do_write   = 1'b1;
               aw_have_d  = 1'b0;
               w_have_d   = 1'b0;
               bvalid_d   = 1'b1;
               bresp_d    = wr_known ? `GDIO_RESP_OKAY
                                     : `GDIO_RESP_SLVERR;
               wr_state_d = GDIO_WR_RESP;
            end
         end
         GDIO_WR_RESP: begin
            if (s_axi_bready) begin
               bvalid_d   = 1'b0;
               wr_state_d = GDIO_WR_COLLECT;
            end
         end
         default: begin
            wr_state_d = GDIO_WR_COLLECT;
         end
      endcase
      awready_d = (wr_state_d == GDIO_WR_COLLECT) && !aw_have_d;
      wready_d  = (wr_state_d == GDIO_WR_COLLECT) && !w_have_d;
   end

   // Write channel registers
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         wr_state_q <= GDIO_WR_COLLECT;
         aw_have_q  <= 1'b0;
         w_have_q   <= 1'b0;
         wa_q       <= 8'h00;
         wd_q       <= 32'h0000_0000;
         ws_q       <= 4'h0;
         awready_q  <= 1'b0;
         wready_q   <= 1'b0;
         bvalid_q   <= 1'b0;
         bresp_q    <= `GDIO_RESP_OKAY;
      end else begin
         wr_state_q <= wr_state_d;
         aw_have_q  <= aw_have_d;
         w_have_q   <= w_have_d;
         wa_q       <= wa_d;
         wd_q       <= wd_d;
         ws_q       <= ws_d;
         awready_q  <= awready_d;
         wready_q   <= wready_d;
         bvalid_q   <= bvalid_d;
         bresp_q    <= bresp_d;
      end
   end

   // Port and control registers; input sample register ignores writes
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         out_q    <= `GDIO_RST_PORT;
         dir_q    <= `GDIO_RST_PORT;
         pud_q    <= 1'b0;
         sleep_q  <= 1'b0;
         extint_q <= `GDIO_RST_PORT;
      end else begin
         out_q <= apply_op(out_op, out_q, wbyte);
         dir_q <= apply_op(dir_op, dir_q, wbyte);
         if (wr_go && hit_sfc) begin
            pud_q <= wd_q[`GDIO_PUD_BIT];
         end
         if (wr_go && hit_slp) begin
            sleep_q <= wd_q[`GDIO_SLEEP_BIT];
         end
         if (wr_go && hit_ext) begin
            extint_q <= wbyte;
         end
      end
   end

   // ****************************************
   // Read channel
   // ****************************************

   // Read decode
   wire rd_out  = s_axi_araddr == `GDIO_OFF_OUT;
   wire rd_dir  = s_axi_araddr == `GDIO_OFF_DIR;
   wire rd_pin  = s_axi_araddr == `GDIO_OFF_PIN;
   wire rd_sfc  = s_axi_araddr == `GDIO_OFF_SFC;
   wire rd_slp  = s_axi_araddr == `GDIO_OFF_SLEEP;
   wire rd_ext  = s_axi_araddr == `GDIO_OFF_EXTINT;
   wire rd_wo   = (s_axi_araddr == `GDIO_OFF_DIR_SET)
                | (s_axi_araddr == `GDIO_OFF_DIR_CLR)
                | (s_axi_araddr == `GDIO_OFF_OUT_SET)
                | (s_axi_araddr == `GDIO_OFF_OUT_CLR);
   wire rd_known = rd_out | rd_dir | rd_pin | rd_sfc
                 | rd_slp | rd_ext | rd_wo;
   wire [31:0] sfc_word = {29'h0000_0000, pud_q, 2'h0};
   wire [31:0] slp_word = {31'h0000_0000, sleep_q};
   wire [31:0] rd_word  = rd_out ? widen(out_q)    :
                          rd_dir ? widen(dir_q)    :
                          rd_pin ? widen(pin_q)    :
                          rd_sfc ? sfc_word        :
                          rd_slp ? slp_word        :
                          rd_ext ? widen(extint_q) : 32'h0000_0000;
   wire ar_take = s_axi_arvalid && arready_q;
   wire rvalid_d = ar_take || (rvalid_q && !s_axi_rready);

   // One read at a time, data held until taken
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         arready_q <= 1'b0;
         rvalid_q  <= 1'b0;
         rdata_q   <= 32'h0000_0000;
         rresp_q   <= `GDIO_RESP_OKAY;
      end else begin
         arready_q <= !rvalid_d;
         rvalid_q  <= rvalid_d;
         if (ar_take) begin
            rdata_q <= rd_word;
            rresp_q <= rd_known ? `GDIO_RESP_OKAY : `GDIO_RESP_SLVERR;
         end
      end
   end

   // ****************************************
   // Pin control
   // ****************************************

   // Overrides reach only pins whose alternate function is on
   wire [PINS-1:0] drv_en  = (alt_enable & alt_drive_enable)
                           | (~alt_enable & dir_q);
   wire [PINS-1:0] drv_val = (alt_enable & alt_drive_value)
                           | (~alt_enable & out_q);

   // Per-pin pull-up: input, output bit one, alternate function off, global disable (pud_q) clear
   wire [PINS-1:0] pu_en = ~alt_enable & ~dir_q & out_q
                         & {PINS{~pud_q}};

   // Pad drivers, cleared while reset is held
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pad_out_q <= `GDIO_RST_PORT;
         pad_oe_q  <= `GDIO_RST_PORT;
         pad_pu_q  <= `GDIO_RST_PORT;
      end else begin
         pad_out_q <= drv_val;
         pad_oe_q  <= drv_en;
         pad_pu_q  <= pu_en & ~drv_en;
      end
   end

   // ****************************************
   // Input synchroniser
   // ****************************************

   // Deep sleep clamps the input low except on interrupt pins
   wire [PINS-1:0] clamp = {PINS{sleep_q}} & ~extint_q;
   wire [PINS-1:0] din   = pad_in & ~clamp;

   // Latch open while the clock is high, closed while low
   always_latch begin
      if (aclk) begin
         sync_lat <= din;
      end
   end

   // Held value loaded at the next rising edge
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pin_q <= `GDIO_RST_PORT;
      end else begin
         pin_q <= sync_lat;
      end
   end

   // ****************************************
   // Outputs
   // ****************************************

   // Every output comes from a flip-flop
   assign s_axi_awready = awready_q;
   assign s_axi_wready  = wready_q;
   assign s_axi_bvalid  = bvalid_q;
   assign s_axi_bresp   = bresp_q;
   assign s_axi_arready = arready_q;
   assign s_axi_rvalid  = rvalid_q;
   assign s_axi_rdata   = rdata_q;
   assign s_axi_rresp   = rresp_q;
   assign pad_out       = pad_out_q;
   assign pad_oe        = pad_oe_q;
   assign pad_pullup_en = pad_pu_q;

endmodule // gdio_port

// File: tb/gdio_port_monitor.sv
// Checker for bus timing and pad control of the digital I/O port
`timescale 1ns/10ps
module gdio_port_monitor #(
   parameter int PINS = 8
) (
   // Clock and reset
   input wire logic              aclk,
   input wire logic              aresetn,
   // Bus handshakes
   input wire logic              s_axi_awvalid,
   input wire logic              s_axi_awready,
   input wire logic              s_axi_wvalid,
   input wire logic              s_axi_wready,
   input wire logic              s_axi_bvalid,
   input wire logic              s_axi_bready,
   input gdio_pkg::gdio_resp_t   s_axi_bresp,
   input wire logic [7:0]        s_axi_araddr,
   input wire logic              s_axi_arvalid,
   input wire logic              s_axi_arready,
   input wire logic              s_axi_rvalid,
   input wire logic              s_axi_rready,
   input wire logic [31:0]       s_axi_rdata,
   input gdio_pkg::gdio_resp_t   s_axi_rresp,
   // Pads and overrides
   input wire logic [PINS-1:0]   alt_enable,
   input wire logic [PINS-1:0]   alt_drive_enable,
   input wire logic [PINS-1:0]   pad_oe,
   input wire logic [PINS-1:0]   pad_pullup_en
);
   // ****************************************
   // Assertions
   // ****************************************
   logic wr_take;
   logic rd_take;
   // Transfer acceptance
   assign wr_take = s_axi_awvalid & s_axi_awready
                  & s_axi_wvalid & s_axi_wready;
   assign rd_take = s_axi_arvalid & s_axi_arready;
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   reset_tristate_a: assert property (disable iff (1'b0)
      !aresetn |=> pad_oe == '0 && pad_pullup_en == '0)
      else $error("pad on in reset");
   no_pull_out_a: assert property ((pad_oe & pad_pullup_en) == '0)
      else $error("pull-up on driven pin");
   alt_no_pull_a: assert property ($past(aresetn) |->
      (pad_pullup_en & $past(alt_enable)) == '0)
      else $error("pull-up on alt pin");
   alt_drive_a: assert property ($past(aresetn) |->
      ((pad_oe ^ $past(alt_drive_enable)) & $past(alt_enable)) == '0)
      else $error("alt drive enable lost");
   wr_resp_time_a: assert property (wr_take |=>
      !s_axi_bvalid ##1 s_axi_bvalid) else $error("write answer late");
   b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=>
      s_axi_bvalid && $stable(s_axi_bresp))
      else $error("bvalid dropped");
   rd_resp_time_a: assert property (rd_take |=> s_axi_rvalid)
      else $error("read answer late");
   r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
      s_axi_rvalid && $stable(s_axi_rdata))
      else $error("rvalid dropped");
   ar_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("arready during read answer");
   unmap_rd_a: assert property (rd_take && s_axi_araddr > 8'h24 |=>
      s_axi_rresp == 2'h2 && s_axi_rdata == '0)
      else $error("unmapped read ok");
   // Main scenarios reached
   cover property (wr_take);
   cover property (rd_take);
   cover property (pad_pullup_en != '0);
   cover property (s_axi_bvalid && s_axi_bresp == 2'h2);
endmodule // gdio_port_monitor

// File: tb/gdio_pins_model.sv
// Board model: resolves the level on each port pin
`timescale 1ns/10ps
module gdio_pins_model (
   // Clock
   input wire logic        aclk,
   // Port side
   input wire logic [7:0]  pad_out,
   input wire logic [7:0]  pad_oe,
   input wire logic [7:0]  pad_pullup_en,
   // Board drivers
   input wire logic [7:0]  ext_en,
   input wire logic [7:0]  ext_val,
   // Level seen by the port
   output logic [7:0]      pad_in
);
   logic [7:0] flt_q = 8'h55;
   // Floating lines toggle so no level is implied
   always_ff @(posedge aclk) flt_q <= ~flt_q;
   // Driver first, then board, then pull-up, else floating
   assign pad_in = (pad_oe & pad_out) | (~pad_oe & ext_en & ext_val)
      | (~pad_oe & ~ext_en & (pad_pullup_en | flt_q));
endmodule // gdio_pins_model

// File: tb/gdio_port_bench.sv
// Testbench: register accesses and pad checks of the digital I/O port
`timescale 1ns/10ps
`include "gdio_cfg.svh"
module gdio_port_bench;
   import gdio_pkg::*;
   // ****************************************
   // Signals
   // ****************************************
   logic aclk = 1'b0, aresetn = 1'b0;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   logic [31:0] s_axi_wdata = 32'h0;
   logic [3:0] s_axi_wstrb = 4'hF;
   logic [7:0] alt_enable = 8'h00, alt_drive_enable = 8'h00;
   logic [7:0] alt_drive_value = 8'h00, ext_en = 8'h00, ext_val = 8'h00;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
   logic s_axi_rvalid;
   gdio_resp_t s_axi_bresp, s_axi_rresp, r;
   logic [31:0] s_axi_rdata, d;
   logic [7:0] pad_in, pad_out, pad_oe, pad_pullup_en;
   int n_mismatch = 0, compares = 0, cyc = 0;
   gdio_port u_gdio_port (.*);
   gdio_pins_model u_gdio_pins_model (.*);
   // Clock and hang guard
   initial forever #5 aclk = ~aclk;
   always @(posedge aclk) begin
      cyc++;
      if (cyc == 3000) begin
         n_mismatch++;
         results();
      end
   end
   // ****************************************
   // Tasks
   // ****************************************
   task automatic chk(input logic [33:0] s, input logic [33:0] e);
      compares++;
      if (s !== e) begin
         n_mismatch++;
         $display("BAD %0t seen %h exp %h", $time, s, e);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      s_axi_awaddr <= a;
      s_axi_wdata <= {24'h0, v};
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
         if (s_axi_bready && s_axi_bvalid) r = s_axi_bresp;
         s_axi_bready <= s_axi_bvalid && !s_axi_bready;
      end while (!(s_axi_bready && s_axi_bvalid));
   endtask
   task automatic w(input logic [7:0] a, input logic [7:0] v);
      wr(a, v);
      chk(34'(r), 34'h0);
   endtask
   task automatic rd(input logic [7:0] a);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
         if (s_axi_rready && s_axi_rvalid) begin
            d = s_axi_rdata;
            r = s_axi_rresp;
         end
         s_axi_rready <= s_axi_rvalid && !s_axi_rready;
      end while (!(s_axi_rready && s_axi_rvalid));
   endtask
   task automatic rchk(input logic [7:0] a, m, e);
      rd(a);
      chk({r, d & {24'h0, m}}, {26'h0, e});
   endtask
   task automatic results();
      $display("mismatches %0d compares %0d", n_mismatch, compares);
      if (n_mismatch == 0 && compares > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   // ****************************************
   // Sequence
   // ****************************************
   initial begin
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      rchk(`GDIO_OFF_OUT, 8'hFF, 8'h00);
      rchk(`GDIO_OFF_DIR, 8'hFF, 8'h00);
      w(`GDIO_OFF_OUT, 8'hFF);
      chk(34'(pad_pullup_en), 34'hFF);
      w(`GDIO_OFF_DIR, 8'h0F);
      chk(34'({pad_oe, pad_out & pad_oe}), 34'h0F0F);
      chk(34'(pad_pullup_en), 34'hF0);
      rchk(`GDIO_OFF_PIN, 8'hFF, 8'hFF);
      w(`GDIO_OFF_SFC, 8'h04);
      chk(34'(pad_pullup_en), 34'h0);
      rchk(`GDIO_OFF_SFC, 8'hFF, 8'h04);
      ext_en <= 8'hF0;
      ext_val <= 8'hA0;
      repeat (2) @(posedge aclk);
      rchk(`GDIO_OFF_PIN, 8'hFF, 8'hAF);
      w(`GDIO_OFF_OUT_CLR, 8'h02);
      w(`GDIO_OFF_DIR_CLR, 8'h08);
      w(`GDIO_OFF_PIN, 8'h00);
      rchk(`GDIO_OFF_OUT, 8'hFF, 8'hFD);
      rchk(`GDIO_OFF_DIR, 8'hFF, 8'h07);
      rchk(`GDIO_OFF_PIN, 8'hF7, 8'hA5);
      alt_enable <= 8'h01;
      alt_drive_enable <= 8'h01;
      repeat (2) @(posedge aclk);
      chk({18'h0, pad_oe, pad_out & pad_oe}, 34'h0704);
      alt_enable <= 8'h00;
      w(`GDIO_OFF_EXTINT, 8'h80);
      w(`GDIO_OFF_SLEEP, 8'h01);
      rchk(`GDIO_OFF_PIN, 8'hFF, 8'h80);
      w(`GDIO_OFF_SLEEP, 8'h00);
      w(`GDIO_OFF_OUT_CLR, 8'h10);
      w(`GDIO_OFF_DIR_SET, 8'h10);
      w(`GDIO_OFF_OUT_SET, 8'h02);
      s_axi_wstrb <= 4'h0;
      w(`GDIO_OFF_OUT, 8'h00);
      s_axi_wstrb <= 4'hF;
      rchk(`GDIO_OFF_OUT, 8'hFF, 8'hEF);
      rchk(`GDIO_OFF_DIR, 8'hFF, 8'h17);
      rchk(`GDIO_OFF_EXTINT, 8'hFF, 8'h80);
      rchk(`GDIO_OFF_DIR_SET, 8'hFF, 8'h00);
      chk(34'({pad_oe, pad_out & pad_oe}), 34'h1707);
      wr(8'h40, 8'h11);
      chk(34'(r), 34'h2);
      rd(8'h40);
      chk({r, d}, {2'h2, 32'h0});
      aresetn <= 1'b0;
      repeat (2) @(posedge aclk);
      chk({18'h0, pad_oe, pad_pullup_en}, 34'h0);
      aresetn <= 1'b1;
      @(posedge aclk);
      rchk(`GDIO_OFF_DIR, 8'hFF, 8'h00);
      results();
   end
endmodule // gdio_port_bench
bind gdio_port gdio_port_monitor #(.PINS(PINS)) u_gdio_port_monitor (.*);
